// ===== include/rcu_pkg.sv
// Package for the reset cause unit: register map, field positions, reset
// values and the structs that carry source, bus and state signals.
// Assumes the printed absolute addresses reach the block unchanged.
package rcu_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_STATUS_A  = 32'h4007F000;
  localparam logic [31:0] ADDR_STATUS_B  = 32'h4007F001;
  localparam logic [31:0] ADDR_FILT_CTL  = 32'h4007F004;
  localparam logic [31:0] ADDR_FILT_WID  = 32'h4007F005;

  localparam logic [7:0]  RST_STATUS_A   = 8'h82;
  localparam logic [7:0]  RST_STATUS_B   = 8'h00;
  localparam logic [7:0]  RST_FILT_CTL   = 8'h00;
  localparam logic [7:0]  RST_FILT_WID   = 8'h00;
  localparam logic [7:0]  FILT_CTL_MASK  = 8'h07;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int A_POWER_UP   = 7;
  localparam int A_EXT_LINE   = 6;
  localparam int A_WATCH      = 5;
  localparam int A_RESERVED   = 4;
  localparam int A_PLL_UNLOCK = 3;
  localparam int A_OSC_MISS   = 2;
  localparam int A_UNDERVOLT  = 1;
  localparam int A_WAKE       = 0;
  localparam int B_STOP_ACK   = 5;
  localparam int B_DEBUGGER   = 3;
  localparam int B_SOFTWARE   = 2;
  localparam int B_LOCKUP     = 1;
  localparam int CTL_STOP_SEL = 2;
  localparam int CTL_RUN_HI   = 1;
  localparam int CTL_RUN_LO   = 0;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ext_reset_n;
    logic watch_timer_expiry;
    logic pll_unlock;
    logic ext_osc_missing;
    logic clock_monitor_en;
    logic undervoltage;
    logic undervolt_reset_enable;
    logic wake_other;
    logic low_leak_stop_mode;
    logic deep_leak_stop_modes;
    logic stop_ack_fail;
    logic debugger_request;
    logic software_request;
    logic core_lockup;
  } rcu_src_t;

  localparam rcu_src_t SRC_IDLE = '{ext_reset_n: 1'b1, default: 1'b0};

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic        supervisor;
  } rcu_bus_req_t;

  typedef struct packed {
    rcu_src_t    sync1;
    rcu_src_t    sync2;
    logic        in_reset;
    logic [7:0]  status_a;
    logic [7:0]  status_b;
    logic [7:0]  filt_ctl;
    logic [7:0]  filt_wid;
    logic [7:0]  pin_cnt;
    logic [7:0]  rdata;
    logic        bus_error;
  } rcu_state_t;

endpackage

// ===== hdl/rcu_reset_cause_unit.sv
// Reset cause unit: captures which on-chip sources caused each reset and
// serves the status and reset-line filter registers on a plain port.
// Assumes rst is the power-on reset and source inputs arrive asynchronously.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps

// How it works
// [RULE_01] User-mode writes are dropped and answered with a bus error pulse.
// [RULE_02] Four 8-bit registers: two read-only status, filter control, filter width.
// [RULE_03] Power-on reset leaves status A at 0x82, power-up and undervoltage set.
// [RULE_04] Undervoltage reset without power-on leaves status A at 0x02.
// [RULE_05] Deep stop wakeup reads 0x41 via reset line, otherwise 0x01.
// [RULE_06] Any other reset sets exactly the flag of its own source.
// [RULE_07] Bit 7 marks power-on, always together with the undervoltage bit.
// [RULE_08] Bit 6 marks a reset from the low external reset line.
// [RULE_09] Bit 5 marks a reset from the run monitor watchdog expiring.
// [RULE_10] Software disables the watchdog by writing 00 to its timeout select.
// [RULE_11] Bit 4 of status A always reads zero.
// [RULE_12] Bit 3 marks a reset from PLL loss of lock.
// [RULE_13] Bit 2 marks external clock loss, only with the clock monitor enabled.
// [RULE_14] Bit 1 marks an enabled undervoltage trip, and is also set at power-on.
// [RULE_15] Bit 0 marks a reset from a low-leakage wakeup source.
// [RULE_16] In low-leak stop only the reset line as wakeup causes a reset.
// [RULE_17] In deep-leak stop any enabled wakeup causes a flagged wakeup reset.
// [RULE_18] The wakeup flag is cleared by every reset that is not a wakeup.
// [RULE_19] Status B flags stop-ack failure, debugger, software and lockup resets.
// [RULE_20] Flags are captured as a reset asserts and held; status writes ignored.
// [RULE_21] Simultaneous sources all get their flags set.
module rcu_reset_cause_unit (
  // Clock and power-on reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Reset sources and mode levels
  input  wire rcu_pkg::rcu_src_t     src,
  // Register port
  input  wire rcu_pkg::rcu_bus_req_t bus,
  output logic [7:0]                 rdata,
  output logic                       bus_error,
  // Chip reset request while any source decodes to a status flag
  output logic                       chip_reset_req
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  rcu_pkg::rcu_state_t st;
  rcu_pkg::rcu_state_t next_st;

  rcu_pkg::rcu_src_t   s;
  logic                pin_low;
  logic                in_stop;
  logic                filt_on;
  logic                pin_ok;
  logic                wake_rst;
  logic [7:0]          cause_a;
  logic [7:0]          cause_b;
  logic                any_cause;
  logic                user_write;
  logic                sup_write;

  // ---------------------------------------------------------------
  // Cause decode
  // ---------------------------------------------------------------
  always_comb begin
    s        = st.sync2;
    pin_low  = ~s.ext_reset_n;
    in_stop  = s.low_leak_stop_mode | s.deep_leak_stop_modes;
    // Stop modes use their own filter select; run and wait use the 2-bit field
    filt_on  = in_stop ? st.filt_ctl[rcu_pkg::CTL_STOP_SEL]
                       : (st.filt_ctl[rcu_pkg::CTL_RUN_HI:rcu_pkg::CTL_RUN_LO] != 2'h0);
    // A filtered line must stay low for the programmed width before it counts
    pin_ok   = pin_low & (~filt_on | (st.pin_cnt >= st.filt_wid));
    // Deep stop: line wake reads 0x41 (line and wake), others 0x01
    wake_rst = (s.deep_leak_stop_modes & (pin_ok | s.wake_other)) // RULE_17 RULE_05
             | (s.low_leak_stop_mode & pin_ok);                   // RULE_16

    // Bits 7 and 4 never come from a cause: only rst sets power-up
    cause_a                        = rcu_pkg::ZERO_BYTE;          // RULE_11
    cause_a[rcu_pkg::A_EXT_LINE]   = pin_ok;                      // RULE_08
    cause_a[rcu_pkg::A_WATCH]      = s.watch_timer_expiry;        // RULE_09
    cause_a[rcu_pkg::A_PLL_UNLOCK] = s.pll_unlock;                // RULE_12
    cause_a[rcu_pkg::A_OSC_MISS]   = s.ext_osc_missing & s.clock_monitor_en; // RULE_13
    // Alone this gives 0x02
    cause_a[rcu_pkg::A_UNDERVOLT]  = s.undervoltage & s.undervolt_reset_enable; // RULE_14 RULE_04
    cause_a[rcu_pkg::A_WAKE]       = wake_rst;                    // RULE_15

    cause_b                        = rcu_pkg::ZERO_BYTE;          // RULE_19
    cause_b[rcu_pkg::B_STOP_ACK]   = s.stop_ack_fail;
    cause_b[rcu_pkg::B_DEBUGGER]   = s.debugger_request;
    cause_b[rcu_pkg::B_SOFTWARE]   = s.software_request;
    cause_b[rcu_pkg::B_LOCKUP]     = s.core_lockup;

    any_cause  = (cause_a != rcu_pkg::ZERO_BYTE) | (cause_b != rcu_pkg::ZERO_BYTE);
    user_write = bus.wr & ~bus.supervisor;
    sup_write  = bus.wr & bus.supervisor;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.sync1 = src;
    next_st.sync2 = st.sync1;

    if (pin_low) begin
      if (st.pin_cnt != 8'hFF) begin
        next_st.pin_cnt = st.pin_cnt + 8'h01;
      end
    end else begin
      next_st.pin_cnt = 8'h00;
    end

    // New reset: replace the record, so stale flags such as wakeup drop out
    next_st.in_reset = any_cause;
    if (any_cause & ~st.in_reset) begin
      next_st.status_a = cause_a;                                 // RULE_06 RULE_18 RULE_20
      next_st.status_b = cause_b;
    end else if (any_cause) begin
      // Sources that join while the reset is held are added, never dropped
      next_st.status_a = st.status_a | cause_a;                   // RULE_21
      next_st.status_b = st.status_b | cause_b;
    end

    if (sup_write) begin
      case (bus.addr)
        rcu_pkg::ADDR_FILT_CTL: begin
          next_st.filt_ctl = bus.wdata & rcu_pkg::FILT_CTL_MASK;
        end
        rcu_pkg::ADDR_FILT_WID: begin
          next_st.filt_wid = bus.wdata;
        end
        default: begin
          next_st.filt_ctl = st.filt_ctl;                         // RULE_20
        end
      endcase
    end
    next_st.bus_error = user_write;                               // RULE_01

    next_st.rdata = rcu_pkg::ZERO_BYTE;
    if (bus.rd) begin
      case (bus.addr)                                             // RULE_02
        rcu_pkg::ADDR_STATUS_A: begin
          next_st.rdata = st.status_a;
        end
        rcu_pkg::ADDR_STATUS_B: begin
          next_st.rdata = st.status_b;
        end
        rcu_pkg::ADDR_FILT_CTL: begin
          next_st.rdata = st.filt_ctl;
        end
        rcu_pkg::ADDR_FILT_WID: begin
          next_st.rdata = st.filt_wid;
        end
        default: begin
          next_st.rdata = rcu_pkg::ZERO_BYTE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st.sync1     <= rcu_pkg::SRC_IDLE;
      st.sync2     <= rcu_pkg::SRC_IDLE;
      st.in_reset  <= 1'b0;
      st.status_a  <= rcu_pkg::RST_STATUS_A;                      // RULE_03 RULE_07
      st.status_b  <= rcu_pkg::RST_STATUS_B;
      st.filt_ctl  <= rcu_pkg::RST_FILT_CTL;
      st.filt_wid  <= rcu_pkg::RST_FILT_WID;
      st.pin_cnt   <= 8'h00;
      st.rdata     <= rcu_pkg::ZERO_BYTE;
      st.bus_error <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata          = st.rdata;
  assign bus_error      = st.bus_error;
  assign chip_reset_req = st.in_reset;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence user_wr_ctl;
    bus.wr && !bus.supervisor && bus.addr == rcu_pkg::ADDR_FILT_CTL;
  endsequence

  sequence reset_starts;
    any_cause && !st.in_reset;
  endsequence

  a_user_write_error: assert property (user_wr_ctl |=> bus_error && $stable(st.filt_ctl)) // RULE_01
    else $error("user write not blocked");

  a_sup_write_taken: assert property (
    sup_write && bus.addr == rcu_pkg::ADDR_FILT_WID |=> st.filt_wid == $past(bus.wdata)) // RULE_02
    else $error("filter width write not stored");

  a_reserved_bit: assert property (!st.status_a[rcu_pkg::A_RESERVED]) // RULE_11
    else $error("reserved status bit set");

  a_por_pair: assert property (
    st.status_a[rcu_pkg::A_POWER_UP] |-> st.status_a[rcu_pkg::A_UNDERVOLT]) // RULE_07
    else $error("power-up flag without undervoltage");

  a_deep_wake_pin: assert property (
    reset_starts ##0 s.deep_leak_stop_modes && pin_ok && cause_b == 8'h00
    && cause_a == 8'h41 |=> st.status_a == 8'h41) // RULE_05
    else $error("deep stop wakeup by line not 0x41");

  a_lls_other_quiet: assert property (
    s.low_leak_stop_mode && !s.deep_leak_stop_modes && !pin_ok |-> !wake_rst) // RULE_16
    else $error("low-leak stop woke from other source");

  a_wake_cleared: assert property (
    reset_starts ##0 !wake_rst |=> !st.status_a[rcu_pkg::A_WAKE]) // RULE_18
    else $error("wakeup flag survived other reset");

  a_osc_gated: assert property (
    reset_starts ##0 !s.clock_monitor_en |=> !st.status_a[rcu_pkg::A_OSC_MISS]) // RULE_13
    else $error("clock loss flagged without monitor");

  a_status_hold: assert property (
    !any_cause && !st.in_reset |=> $stable(st.status_a) && $stable(st.status_b)) // RULE_20
    else $error("status changed outside reset");

  a_all_sources: assert property (
    reset_starts ##0 s.pll_unlock && s.watch_timer_expiry |=>
    st.status_a[rcu_pkg::A_PLL_UNLOCK] && st.status_a[rcu_pkg::A_WATCH]) // RULE_21
    else $error("simultaneous source flag dropped");

  a_status_b_map: assert property (
    reset_starts ##0 s.software_request |=> st.status_b[rcu_pkg::B_SOFTWARE]) // RULE_19
    else $error("software reset not flagged");

  a_read_one_cycle: assert property (
    !bus.rd |=> rdata == 8'h00) // RULE_02
    else $error("read data outside read answer");

endmodule

// ===== verif/rcu_src_model.sv
// Model of the on-chip reset sources that face the reset cause unit.
// Assumes the bench requests source levels on want; they appear one edge later.
`timescale 1ns/10ps
module rcu_src_model (
  // Clock
  input  wire logic              ref_clk,
  // Requests from the bench
  input  wire rcu_pkg::rcu_src_t want,
  input  wire logic [1:0]        run_monitor_timeout_sel,
  // Levels seen by the unit
  output rcu_pkg::rcu_src_t      src
);
  rcu_pkg::rcu_src_t gated;
  always_comb begin
    gated = want;
    // A watchdog switched off by software can never expire
    if (run_monitor_timeout_sel == 2'b00) begin
      gated.watch_timer_expiry = 1'b0;
    end
  end
  initial src = rcu_pkg::SRC_IDLE;
  always @(posedge ref_clk) begin
    src <= gated;
  end
endmodule

// ===== verif/tb.sv
// Self-checking bench for the reset cause unit: register port and reset sources.
// Assumes the source model and the design share ref_clk; no other stimulus.
`timescale 1ns/10ps
`define CHK(a, e) begin \
  n_compared++; \
  if ((a) !== (e)) begin \
    err_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, e); \
  end \
end
module tb;
  logic                  ref_clk;
  logic                  rst;
  rcu_pkg::rcu_src_t     want;
  rcu_pkg::rcu_src_t     src;
  rcu_pkg::rcu_bus_req_t bus;
  logic [1:0]            sel;
  logic [7:0]            rdata;
  logic                  bus_error;
  logic                  chip_reset_req;
  int                    err_count;
  int                    n_compared;

  rcu_src_model model (
    .ref_clk                 (ref_clk),
    .want                    (want),
    .run_monitor_timeout_sel (sel),
    .src                     (src)
  );
  rcu_reset_cause_unit dut (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .src            (src),
    .bus            (bus),
    .rdata          (rdata),
    .bus_error      (bus_error),
    .chip_reset_req (chip_reset_req)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Flip bits of the idle source word; bit 13 flipped pulls the line low
  function automatic rcu_pkg::rcu_src_t mk(input logic [13:0] flip);
    return rcu_pkg::SRC_IDLE ^ flip;
  endfunction

  task automatic wr_reg(input logic [31:0] a, input logic [7:0] d, input logic sv,
                        input logic exp_err);
    @(posedge ref_clk);
    bus.addr       <= a;
    bus.wdata      <= d;
    bus.supervisor <= sv;
    bus.wr         <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    #1;
    `CHK(bus_error, exp_err)
  endtask

  task automatic rd_reg(input logic [31:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    `CHK(rdata, exp)
  endtask

  // Sources held for six edges; the request needs four: one in the model, two of sync, one to decode
  task automatic cause(input rcu_pkg::rcu_src_t s, input logic [7:0] ea,
                       input logic [7:0] eb, input logic ereq);
    @(posedge ref_clk);
    want <= s;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK(chip_reset_req, ereq)
    want <= rcu_pkg::SRC_IDLE;
    repeat (6) @(posedge ref_clk);
    rd_reg(rcu_pkg::ADDR_STATUS_A, ea);
    rd_reg(rcu_pkg::ADDR_STATUS_B, eb);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    err_count  = 0;
    n_compared = 0;
    rst        = 1'b1;
    want       = rcu_pkg::SRC_IDLE;
    bus        = '0;
    sel        = 2'b11;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(rcu_pkg::ADDR_STATUS_A, 8'h82);
    rd_reg(rcu_pkg::ADDR_STATUS_B, 8'h00);
    rd_reg(rcu_pkg::ADDR_FILT_CTL, 8'h00);
    rd_reg(rcu_pkg::ADDR_FILT_WID, 8'h00);
    rd_reg(32'h4007F002, 8'h00);
    wr_reg(rcu_pkg::ADDR_FILT_WID, 8'h5A, 1'b0, 1'b1);
    rd_reg(rcu_pkg::ADDR_FILT_WID, 8'h00);
    wr_reg(rcu_pkg::ADDR_FILT_CTL, 8'hFF, 1'b1, 1'b0);
    rd_reg(rcu_pkg::ADDR_FILT_CTL, 8'h07);
    wr_reg(rcu_pkg::ADDR_FILT_CTL, 8'h02, 1'b0, 1'b1);
    rd_reg(rcu_pkg::ADDR_FILT_CTL, 8'h07);
    wr_reg(rcu_pkg::ADDR_FILT_WID, 8'hA5, 1'b1, 1'b0);
    rd_reg(rcu_pkg::ADDR_FILT_WID, 8'hA5);
    wr_reg(rcu_pkg::ADDR_STATUS_A, 8'h00, 1'b1, 1'b0);
    rd_reg(rcu_pkg::ADDR_STATUS_A, 8'h82);
    // Filtering off again so the line acts at once
    wr_reg(rcu_pkg::ADDR_FILT_CTL, 8'h00, 1'b1, 1'b0);
    cause(mk(14'h0800), 8'h08, 8'h00, 1'b1);
    cause(mk(14'h0400), 8'h08, 8'h00, 1'b0);
    cause(mk(14'h0600), 8'h04, 8'h00, 1'b1);
    cause(mk(14'h1000), 8'h20, 8'h00, 1'b1);
    cause(mk(14'h2000), 8'h40, 8'h00, 1'b1);
    cause(mk(14'h0180), 8'h02, 8'h00, 1'b1);
    cause(mk(14'h0100), 8'h02, 8'h00, 1'b0);
    cause(mk(14'h0050), 8'h01, 8'h00, 1'b1);
    cause(mk(14'h0060), 8'h01, 8'h00, 1'b0);
    cause(mk(14'h2010), 8'h41, 8'h00, 1'b1);
    cause(mk(14'h2020), 8'h41, 8'h00, 1'b1);
    cause(mk(14'h1800), 8'h28, 8'h00, 1'b1);
    cause(mk(14'h0008), 8'h00, 8'h20, 1'b1);
    cause(mk(14'h0004), 8'h00, 8'h08, 1'b1);
    cause(mk(14'h0002), 8'h00, 8'h04, 1'b1);
    cause(mk(14'h0001), 8'h00, 8'h02, 1'b1);
    sel <= 2'b00;
    cause(mk(14'h1000), 8'h00, 8'h02, 1'b0);
    // Second power-on in mid-run
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(rcu_pkg::ADDR_STATUS_A, 8'h82);
    rd_reg(rcu_pkg::ADDR_FILT_WID, 8'h00);
    finish_test();
  end
endmodule
